// ---- src/fpc_pkg.sv ----
// shared formats, widths, biases and byte counts for the float classifier
package fpc_pkg;

    // ==========================================================
    // format select codes
    typedef enum logic [1:0] {
        FMT_HALF   = 2'h0,
        FMT_SINGLE = 2'h1,
        FMT_DOUBLE = 2'h2,
        FMT_EXT    = 2'h3
    } fpc_fmt_t;

    // ==========================================================
    // class codes, one-hot
    localparam int CLASS_W = 8;
    localparam logic [7:0] CLS_ZERO   = 8'h01;
    localparam logic [7:0] CLS_DENORM = 8'h02;
    localparam logic [7:0] CLS_NORMAL = 8'h04;
    localparam logic [7:0] CLS_INF    = 8'h08;
    localparam logic [7:0] CLS_SNAN   = 8'h10;
    localparam logic [7:0] CLS_QNAN   = 8'h20;
    localparam logic [7:0] CLS_INDEF  = 8'h40;
    localparam logic [7:0] CLS_UNSUPP = 8'h80;

    // ==========================================================
    // field widths
    localparam int HALF_EXP_W = 5;
    localparam int HALF_FRC_W = 10;
    localparam int SGL_EXP_W  = 8;
    localparam int SGL_FRC_W  = 23;
    localparam int DBL_EXP_W  = 11;
    localparam int DBL_FRC_W  = 52;
    localparam int EXT_EXP_W  = 15;
    localparam int EXT_FRC_W  = 63;
    localparam int EXT_INT_BIT = 63;
    localparam int EXT_FMSB    = 62;
    localparam int EXT_SIGN    = 79;
    localparam int WORD_W  = 80;
    localparam int SIG_W   = 64;
    localparam int UEXP_W  = 17;

    // ==========================================================
    // exponent biases
    localparam logic [15:0] HALF_BIAS = 16'h000F;
    localparam logic [15:0] SGL_BIAS  = 16'h007F;
    localparam logic [15:0] DBL_BIAS  = 16'h03FF;
    localparam logic [15:0] EXT_BIAS  = 16'h3FFF;

    // ==========================================================
    // memory byte counts
    localparam logic [3:0] HALF_BYTES = 4'h2;
    localparam logic [3:0] SGL_BYTES  = 4'h4;
    localparam logic [3:0] DBL_BYTES  = 4'h8;
    localparam logic [3:0] EXT_BYTES  = 4'hA;

endpackage : fpc_pkg

// ---- src/fpc_field.sv ----
// one format slice: splits a packed value and classifies it
`timescale 1ns/10ps
`default_nettype none

module fpc_field #(
    parameter int EXP_W      = 8,
    parameter int FRC_W      = 23,
    parameter bit EXPLICIT_J = 1'b0
) (
    input  wire logic [fpc_pkg::WORD_W-1:0]  i_word,
    output logic                             o_sign,
    output logic [EXP_W-1:0]                 o_exp,
    output logic [FRC_W-1:0]                 o_frac,
    output logic                             o_jbit,
    output logic [fpc_pkg::CLASS_W-1:0]      o_class
);
    logic exp_zero;
    logic exp_ones;
    logic frc_zero;

    // ==========================================================
    // field split
    always_comb begin
        o_sign   = i_word[EXP_W+FRC_W+(EXPLICIT_J ? 1 : 0)];
        o_exp    = i_word[FRC_W+(EXPLICIT_J ? 1 : 0) +: EXP_W];
        o_frac   = i_word[FRC_W-1:0];
        exp_zero = (o_exp == '0);
        exp_ones = (o_exp == '1);
        frc_zero = (o_frac == '0);
        // implied integer bit unless zero or denormal
        o_jbit   = EXPLICIT_J ? i_word[FRC_W] : !exp_zero;
    end

    // ==========================================================
    // classification; sign affects only the indefinite nan class
    always_comb begin
        if (exp_zero && frc_zero) begin
            o_class = fpc_pkg::CLS_ZERO;
        end else if (exp_zero) begin
            o_class = fpc_pkg::CLS_DENORM;
        end else if (!exp_ones) begin
            o_class = fpc_pkg::CLS_NORMAL;
        end else if (frc_zero) begin
            o_class = fpc_pkg::CLS_INF;
        end else if (!o_frac[FRC_W-1]) begin
            o_class = fpc_pkg::CLS_SNAN;
        end else if (o_sign && o_frac[FRC_W-2:0] == '0) begin
            o_class = fpc_pkg::CLS_QNAN | fpc_pkg::CLS_INDEF;
        end else begin
            o_class = fpc_pkg::CLS_QNAN;
        end
    end
endmodule : fpc_field

`default_nettype wire

// ---- src/fpc_top.sv ----
// float operand classifier, unbiaser and builder with one output stage
`timescale 1ns/10ps
`default_nettype none

module fpc_top (
    input  wire logic                          I_REF_CLK,
    input  wire logic                          I_RESET,
    input  wire logic                          i_valid,
    input  wire logic [1:0]                    i_fmt,
    input  wire logic                          i_arith,
    input  wire logic [fpc_pkg::WORD_W-1:0]    i_word,
    input  wire logic                          i_build,
    input  wire logic                          i_build_indef,
    input  wire logic                          i_build_sign,
    input  wire logic [fpc_pkg::UEXP_W-1:0]    i_build_uexp,
    input  wire logic [fpc_pkg::SIG_W-1:0]     i_build_sig,
    input  wire logic [fpc_pkg::CLASS_W-1:0]   i_build_class,
    output logic                               o_valid,
    output logic [fpc_pkg::CLASS_W-1:0]        o_class,
    output logic                               o_sign,
    output logic [fpc_pkg::UEXP_W-1:0]         o_uexp,
    output logic [fpc_pkg::SIG_W-1:0]          o_sig,
    output logic [3:0]                         o_bytes,
    output logic [fpc_pkg::WORD_W-1:0]         o_word
);
    // ==========================================================
    // per-format slices
    logic       h_s, s_s, d_s, e_s;
    logic       h_j, s_j, d_j, e_j;
    logic [fpc_pkg::HALF_EXP_W-1:0] h_e;
    logic [fpc_pkg::SGL_EXP_W-1:0]  s_e;
    logic [fpc_pkg::DBL_EXP_W-1:0]  d_e;
    logic [fpc_pkg::EXT_EXP_W-1:0]  e_e;
    logic [fpc_pkg::HALF_FRC_W-1:0] h_f;
    logic [fpc_pkg::SGL_FRC_W-1:0]  s_f;
    logic [fpc_pkg::DBL_FRC_W-1:0]  d_f;
    logic [fpc_pkg::EXT_FRC_W-1:0]  e_f;
    logic [fpc_pkg::CLASS_W-1:0]    h_c, s_c, d_c, e_c;

    fpc_field #(.EXP_W(fpc_pkg::HALF_EXP_W), .FRC_W(fpc_pkg::HALF_FRC_W),
                .EXPLICIT_J(1'b0)) u_half (.i_word(i_word), .o_sign(h_s),
        .o_exp(h_e), .o_frac(h_f), .o_jbit(h_j), .o_class(h_c));
    fpc_field #(.EXP_W(fpc_pkg::SGL_EXP_W), .FRC_W(fpc_pkg::SGL_FRC_W),
                .EXPLICIT_J(1'b0)) u_sgl (.i_word(i_word), .o_sign(s_s),
        .o_exp(s_e), .o_frac(s_f), .o_jbit(s_j), .o_class(s_c));
    fpc_field #(.EXP_W(fpc_pkg::DBL_EXP_W), .FRC_W(fpc_pkg::DBL_FRC_W),
                .EXPLICIT_J(1'b0)) u_dbl (.i_word(i_word), .o_sign(d_s),
        .o_exp(d_e), .o_frac(d_f), .o_jbit(d_j), .o_class(d_c));
    fpc_field #(.EXP_W(fpc_pkg::EXT_EXP_W), .FRC_W(fpc_pkg::EXT_FRC_W),
                .EXPLICIT_J(1'b1)) u_ext (.i_word(i_word), .o_sign(e_s),
        .o_exp(e_e), .o_frac(e_f), .o_jbit(e_j), .o_class(e_c));

    // ==========================================================
    // next-value logic
    logic                        next_valid;
    logic [fpc_pkg::CLASS_W-1:0] next_class;
    logic                        next_sign;
    logic [fpc_pkg::UEXP_W-1:0]  next_uexp;
    logic [fpc_pkg::SIG_W-1:0]   next_sig;
    logic [3:0]                  next_bytes;
    logic [fpc_pkg::WORD_W-1:0]  next_word;
    logic [fpc_pkg::UEXP_W-1:0]  bias;
    logic [fpc_pkg::UEXP_W-1:0]  bexp;
    logic                        bjbit;
    logic                        is_nan_inf;

    always_comb begin
        next_valid = i_valid;
        next_class = '0;
        next_sign  = 1'b0;
        next_uexp  = '0;
        next_sig   = '0;
        next_bytes = 4'h0;
        next_word  = '0;
        bias       = '0;
        bexp       = '0;
        bjbit      = 1'b0;
        is_nan_inf = |(i_build_class & (fpc_pkg::CLS_INF | fpc_pkg::CLS_SNAN
                       | fpc_pkg::CLS_QNAN | fpc_pkg::CLS_INDEF));
        unique case (fpc_pkg::fpc_fmt_t'(i_fmt))
            fpc_pkg::FMT_HALF: begin
                bias       = {1'b0, fpc_pkg::HALF_BIAS};
                next_bytes = fpc_pkg::HALF_BYTES;
                next_class = h_c;
                next_sign  = h_s;
                next_sig   = {h_j, h_f, 53'h0_0000_0000_0000};
                next_uexp  = UEXP_OF(17'(h_e), h_c);
            end
            fpc_pkg::FMT_SINGLE: begin
                bias       = {1'b0, fpc_pkg::SGL_BIAS};
                next_bytes = fpc_pkg::SGL_BYTES;
                next_class = s_c;
                next_sign  = s_s;
                next_sig   = {s_j, s_f, 40'h00_0000_0000};
                next_uexp  = UEXP_OF(17'(s_e), s_c);
            end
            fpc_pkg::FMT_DOUBLE: begin
                bias       = {1'b0, fpc_pkg::DBL_BIAS};
                next_bytes = fpc_pkg::DBL_BYTES;
                next_class = d_c;
                next_sign  = d_s;
                next_sig   = {d_j, d_f, 11'h000};
                next_uexp  = UEXP_OF(17'(d_e), d_c);
            end
            fpc_pkg::FMT_EXT: begin
                bias       = {1'b0, fpc_pkg::EXT_BIAS};
                next_bytes = fpc_pkg::EXT_BYTES;
                next_class = e_c;
                next_sign  = e_s;
                next_sig   = {e_j, e_f};
                next_uexp  = UEXP_OF(17'(e_e), e_c);
            end
        endcase
        // half as arithmetic operand is refused, flagged unsupported
        if (i_arith && i_fmt == fpc_pkg::FMT_HALF) begin
            next_class = fpc_pkg::CLS_UNSUPP;
        end
        // build path: biased exponent and packed word
        bexp  = 17'(i_build_uexp + bias);
        bjbit = is_nan_inf | (|(i_build_class & fpc_pkg::CLS_NORMAL));
        if (i_build) begin
            unique case (fpc_pkg::fpc_fmt_t'(i_fmt))
                fpc_pkg::FMT_HALF: next_word = 80'(
                    {BSIGN(i_build_sign), BEXP5(bexp), i_build_sig[62:53]});
                fpc_pkg::FMT_SINGLE: next_word = 80'(
                    {BSIGN(i_build_sign), BEXP8(bexp), i_build_sig[62:40]});
                fpc_pkg::FMT_DOUBLE: next_word = 80'(
                    {BSIGN(i_build_sign), BEXP11(bexp), i_build_sig[62:11]});
                fpc_pkg::FMT_EXT: next_word = {BSIGN(i_build_sign),
                    BEXP15(bexp), bjbit, i_build_sig[62:0]};
            endcase
            if (i_build_indef) begin
                // quiet indefinite: sign set, exponent all ones, top bit
                unique case (fpc_pkg::fpc_fmt_t'(i_fmt))
                    fpc_pkg::FMT_HALF:   next_word = 80'(16'hFE00);
                    fpc_pkg::FMT_SINGLE: next_word = 80'(32'hFFC0_0000);
                    fpc_pkg::FMT_DOUBLE:
                        next_word = 80'(64'hFFF8_0000_0000_0000);
                    fpc_pkg::FMT_EXT:
                        next_word = 80'hFFFF_C000_0000_0000_0000;
                endcase
            end
        end
    end

    // unbiased exponent; denormals use one in place of zero, all ones is unbiased too
    function automatic logic [16:0] UEXP_OF(input logic [16:0] e,
                                            input logic [7:0] c);
        // denormals use emin, so unbias one instead of zero
        logic [16:0] eff;
        eff = (c == fpc_pkg::CLS_DENORM) ? 17'h0_0001 : e;
        return 17'(eff - bias);
    endfunction : UEXP_OF

    function automatic logic BSIGN(input logic s);
        return s;
    endfunction : BSIGN

    // special classes take the reserved exponents
    function automatic logic [4:0] BEXP5(input logic [16:0] b);
        return is_nan_inf ? 5'h1F : (bjbit ? b[4:0] : 5'h00);
    endfunction : BEXP5
    function automatic logic [7:0] BEXP8(input logic [16:0] b);
        return is_nan_inf ? 8'hFF : (bjbit ? b[7:0] : 8'h00);
    endfunction : BEXP8
    function automatic logic [10:0] BEXP11(input logic [16:0] b);
        return is_nan_inf ? 11'h7FF : (bjbit ? b[10:0] : 11'h000);
    endfunction : BEXP11
    function automatic logic [14:0] BEXP15(input logic [16:0] b);
        return is_nan_inf ? 15'h7FFF : (bjbit ? b[14:0] : 15'h0000);
    endfunction : BEXP15

    // ==========================================================
    // output stage; one cycle of latency keeps timing at 200 MHz
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            o_valid <= 1'b0;
            o_class <= '0;
            o_sign  <= 1'b0;
            o_uexp  <= '0;
            o_sig   <= '0;
            o_bytes <= 4'h0;
            o_word  <= '0;
        end else begin
            o_valid <= next_valid;
            o_class <= next_class;
            o_sign  <= next_sign;
            o_uexp  <= next_uexp;
            o_sig   <= next_sig;
            o_bytes <= next_bytes;
            o_word  <= next_word;
        end
    end
endmodule : fpc_top

`default_nettype wire

// ---- verif/fpc_opnd_model.sv ----
// operand source standing in for the load path ahead of the classifier
`timescale 1ns/10ps
`default_nettype none
module fpc_opnd_model (
    input  wire logic [1:0]  i_fmt,
    input  wire logic [2:0]  i_kind,
    input  wire logic        i_sign,
    input  wire logic [63:0] i_rnd,
    output var  logic [79:0] o_word
);
    localparam int FW_T [4] = '{10, 23, 52, 63};
    localparam int EW_T [4] = '{5, 8, 11, 15};
    // ==========================================================
    // kinds: zero, denorm, normal, inf, snan, qnan, indefinite
    always_comb begin
        int          fw;
        logic        x;
        logic [15:0] mx;
        logic [15:0] e;
        logic [63:0] fr;
        logic [63:0] top;
        fw  = FW_T[i_fmt];
        x   = (i_fmt == 2'h3);
        mx  = 16'((32'h1 << EW_T[i_fmt]) - 1);
        top = 64'h1 << (fw - 1);
        fr  = i_rnd & ((64'h1 << fw) - 1);
        e   = mx;
        case (i_kind)
            3'h0: begin e = 16'h0; fr = 64'h0; end
            3'h1: begin e = 16'h0; fr = fr | 64'h1; end
            3'h2: e = 16'(1 + i_rnd[63:48] % (mx - 1));
            3'h3: fr = 64'h0;
            3'h4: fr = (fr & ~top) | 64'h1;
            3'h5: fr = fr | top;
            default: fr = top;
        endcase
        // explicit integer bit only in the extended form
        o_word = 80'(fr) | (80'(x && e != 16'h0) << 63)
               | (80'(e) << (fw + 32'(x)))
               | (80'(i_sign || i_kind == 3'h6) << (EW_T[i_fmt] + fw + 32'(x)));
    end
endmodule : fpc_opnd_model
`default_nettype wire

// ---- verif/fpc_top_chk.sv ----
// port assertions for the float classifier
`timescale 1ns/10ps
`default_nettype none
module fpc_top_chk (
    input wire logic        I_REF_CLK,
    input wire logic        I_RESET,
    input wire logic [1:0]  i_fmt,
    input wire logic        i_arith,
    input wire logic [79:0] i_word,
    input wire logic        i_build,
    input wire logic        i_build_indef,
    input wire logic [7:0]  i_build_class,
    input wire logic [7:0]  o_class,
    input wire logic        o_sign,
    input wire logic [16:0] o_uexp,
    input wire logic [63:0] o_sig,
    input wire logic [3:0]  o_bytes,
    input wire logic [79:0] o_word
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RESET);
    // ==========================================================
    // operand shapes
    sequence s_sgl_nan;
        i_fmt == 2'h1 && i_word[30:23] == 8'hFF && i_word[22:0] != 23'h0;
    endsequence
    sequence s_ext_norm;
        i_fmt == 2'h3 && i_word[78:64] != 15'h0 && i_word[78:64] != 15'h7FFF;
    endsequence
    // ==========================================================
    // assertions
    a_half_unsupp: assert property (i_fmt == 2'h0 && i_arith
        |=> o_class == 8'h80) else $error("half arith accepted");
    a_byte_count: assert property (1'b1 |=> o_bytes ==
        ($past(i_fmt) == 2'h3 ? 4'hA : 4'h2 << $past(i_fmt)))
        else $error("byte count wrong");
    a_sgl_zero: assert property (i_fmt == 2'h1 && i_word[30:0] == 31'h0
        |=> o_class == 8'h01 && !o_sig[63]) else $error("zero wrong");
    a_sgl_denorm: assert property (i_fmt == 2'h1 && i_word[30:23] == 8'h0
        && i_word[22:0] != 23'h0 |=> o_class == 8'h02 && !o_sig[63]
        && o_uexp == 17'h1_FF82) else $error("denormal wrong");
    a_dbl_normal: assert property (i_fmt == 2'h2 && i_word[62:52] != 11'h0
        && i_word[62:52] != 11'h7FF |=> o_class == 8'h04 && o_sig[63]
        && o_uexp + 17'h3FF == {6'h0, $past(i_word[62:52])})
        else $error("double normal wrong");
    a_ext_fields: assert property (s_ext_norm |=>
        o_sig == $past(i_word[63:0])
        && o_uexp + 17'h3FFF == {2'h0, $past(i_word[78:64])})
        else $error("extended fields wrong");
    a_inf_sign: assert property (i_fmt == 2'h1
        && i_word[30:0] == 31'h7F80_0000 |=> o_class == 8'h08
        && o_sign == $past(i_word[31])) else $error("infinity wrong");
    a_snan_flag: assert property (s_sgl_nan ##0 !i_word[22]
        |=> o_class == 8'h10) else $error("signaling nan missed");
    a_qnan_flag: assert property (s_sgl_nan ##0 i_word[22] && !i_word[31]
        |=> o_class == 8'h20) else $error("quiet nan missed");
    a_indef_flag: assert property (i_fmt == 2'h1
        && i_word[31:0] == 32'hFFC0_0000 |=> o_class == 8'h60)
        else $error("indefinite missed");
    a_build_indef: assert property (i_build && i_build_indef
        && i_fmt == 2'h2 |=> o_word == 80'hFFF8_0000_0000_0000)
        else $error("built indefinite wrong");
    a_build_jbit: assert property (i_build && !i_build_indef && i_fmt == 2'h3
        && (i_build_class == 8'h04 || i_build_class == 8'h01)
        |=> o_word[63] == $past(i_build_class[2])) else $error("integer bit wrong");
endmodule : fpc_top_chk
bind fpc_top fpc_top_chk u_chk (.I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET),
    .i_fmt(i_fmt), .i_arith(i_arith), .i_word(i_word), .i_build(i_build),
    .i_build_indef(i_build_indef), .i_build_class(i_build_class),
    .o_class(o_class), .o_sign(o_sign), .o_uexp(o_uexp), .o_sig(o_sig),
    .o_bytes(o_bytes), .o_word(o_word));
`default_nettype wire

// ---- verif/fpc_top_tb.sv ----
// random and corner stimulus with self checks for the float classifier
`timescale 1ns/10ps
`default_nettype none
module fpc_top_tb;
    // ==========================================================
    // signals
    logic I_REF_CLK = 1'b0, I_RESET = 1'b1, i_valid = 1'b0, i_arith = 1'b0;
    logic i_build = 1'b0, i_build_indef = 1'b0, i_build_sign = 1'b0;
    logic m_sign = 1'b0, live = 1'b0, e_valid, o_valid, o_sign, e_sign;
    logic [1:0]  i_fmt = 2'h0;
    logic [2:0]  m_kind = 3'h0;
    logic [63:0] m_rnd = 64'h0, i_build_sig = 64'h0, o_sig, e_sig;
    logic [16:0] i_build_uexp = 17'h0, o_uexp, e_uexp;
    logic [7:0]  i_build_class = 8'h0, o_class, e_class;
    logic [3:0]  o_bytes, e_bytes;
    logic [79:0] o_word, e_word;
    wire logic [79:0] i_word;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    localparam int FW_T [4] = '{10, 23, 52, 63};
    localparam int EW_T [4] = '{5, 8, 11, 15};
    localparam int BS_T [4] = '{15, 127, 1023, 16383};
    localparam int BY_T [4] = '{2, 4, 8, 10};
    localparam logic [79:0] IND_T [4] = '{80'hFE00, 80'hFFC0_0000,
        80'hFFF8_0000_0000_0000, 80'hFFFF_C000_0000_0000_0000};
    always #2.5 I_REF_CLK = ~I_REF_CLK;
    fpc_opnd_model u_src (.i_fmt(i_fmt), .i_kind(m_kind), .i_sign(m_sign),
        .i_rnd(m_rnd), .o_word(i_word));
    fpc_top uut (
        .I_REF_CLK     (I_REF_CLK),
        .I_RESET       (I_RESET),
        .i_valid       (i_valid),
        .i_fmt         (i_fmt),
        .i_arith       (i_arith),
        .i_word        (i_word),
        .i_build       (i_build),
        .i_build_indef (i_build_indef),
        .i_build_sign  (i_build_sign),
        .i_build_uexp  (i_build_uexp),
        .i_build_sig   (i_build_sig),
        .i_build_class (i_build_class),
        .o_valid       (o_valid),
        .o_class       (o_class),
        .o_sign        (o_sign),
        .o_uexp        (o_uexp),
        .o_sig         (o_sig),
        .o_bytes       (o_bytes),
        .o_word        (o_word)
    );
    // ==========================================================
    // expectation and checks
    task automatic predict(input logic [1:0] f, input logic a, input logic b,
                           input logic bd);
        int          x;
        logic        s;
        logic [15:0] e;
        logic [63:0] fr;
        logic [63:0] top;
        x   = int'(f == 2'h3);
        s   = i_word[EW_T[f] + FW_T[f] + x];
        e   = 16'((i_word >> (FW_T[f] + x)) & ((80'h1 << EW_T[f]) - 1));
        fr  = 64'(i_word & ((80'h1 << FW_T[f]) - 1));
        top = 64'h1 << (FW_T[f] - 1);
        e_class = (f == 2'h0 && a) ? 8'h80 : e == 16'h0 ?
            (fr == 64'h0 ? 8'h01 : 8'h02) : e != 16'((1 << EW_T[f]) - 1) ?
            8'h04 : fr == 64'h0 ? 8'h08 : (fr & top) == 64'h0 ? 8'h10 :
            (s && fr == top) ? 8'h60 : 8'h20;
        e_sign  = s;
        e_uexp  = 17'((e == 16'h0 && fr != 64'h0 ? 1 : int'(e)) - BS_T[f]);
        e_sig   = x == 1 ? i_word[63:0] : {e != 16'h0, 63'(fr << (63 - FW_T[f]))};
        e_bytes = 4'(BY_T[f]);
        e_valid = i_valid;
        e_word  = !b ? 80'h0 : bd ? IND_T[f] : i_word;
        i_build       = b;
        i_build_indef = bd;
        i_build_sign  = s;
        i_build_uexp  = e_uexp;
        i_build_sig   = e_sig;
        i_build_class = e_class & 8'hBF;
    endtask : predict
    task automatic chk(input logic ok, input string m);
        num_checks++;
        if (!ok) begin
            error_cnt++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk
    task automatic step(input logic [1:0] f, input logic [2:0] k,
                        input logic a, input logic b, input logic bd);
        @(posedge I_REF_CLK);
        #1;
        if (live) begin
            chk(o_valid === e_valid, "valid");
            chk(o_class === e_class, "class");
            chk(o_bytes === e_bytes, "bytes");
            chk(o_word === e_word, "word");
            if (e_class != 8'h80) begin
                chk(o_sign === e_sign, "sign");
                chk(o_uexp === e_uexp, "exponent");
                chk(o_sig === e_sig, "significand");
            end
        end
        i_fmt   = f;
        i_arith = a;
        i_valid = 1'($urandom);
        m_kind  = k;
        m_sign  = 1'($urandom);
        m_rnd   = {$urandom, $urandom};
        // let the operand source settle before building from it
        #1;
        predict(f, a, b && !(f == 2'h0 && a), bd);
        live = 1'b1;
    endtask : step
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    // ==========================================================
    // run
    always @(posedge I_REF_CLK) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        void'($urandom(32'h6eb4));
        repeat (16) @(posedge I_REF_CLK);
        #1 I_RESET = 1'b0;
        for (int f = 0; f < 4; f++) begin
            for (int k = 0; k < 7; k++) begin
                step(2'(f), 3'(k), 1'b0, 1'b1, 1'b0);
                step(2'(f), 3'(k), 1'b1, 1'b0, 1'b0);
            end
            step(2'(f), 3'h2, 1'b0, 1'b1, 1'b1);
        end
        repeat (400) step(2'($urandom), 3'($urandom_range(6)),
            $urandom % 8 == 0, 1'($urandom), $urandom % 4 == 0);
        step(2'h1, 3'h2, 1'b0, 1'b0, 1'b0);
        close_out();
    end
endmodule : fpc_top_tb
`default_nettype wire
